// [design/burst_engine.sv]
/*
 * burst sequencer of a double-data-rate memory device: command decode,
 * read and write latency, seamless and interrupted bursts, burst stop.
 * assumes the controller drives commands and write data on LINK_CK, one
 * rise/fall data pair per link cycle, and keeps all spacing rules.
 */
`timescale 1ns/1ps
module burst_engine #(
   parameter int BL = burst_pkg::BL_DEF,
   parameter int RL = burst_pkg::RL_DEF,
   parameter int WL = burst_pkg::WL_DEF,
   parameter int DATA_W = burst_pkg::DATA_W_DEF,
   parameter int MEM_AW = burst_pkg::MEM_AW_DEF
) (
   input wire logic CLOCK,
   input wire logic RSTN,
   input wire logic LINK_CK,
   input wire logic SELECT_N,
   input wire logic [burst_pkg::CA_W-1:0] CMD_ADDR_BUS,
   input wire logic [DATA_W-1:0] WDATA_RISE,
   input wire logic [DATA_W-1:0] WDATA_FALL,
   output logic [DATA_W-1:0] RDATA_RISE,
   output logic [DATA_W-1:0] RDATA_FALL,
   output logic DQ_OE_N,
   output logic DQS_OE_N,
   output logic DQS_RUN,
   output logic EVENT_VALID,
   output logic EVENT_READ,
   output logic [burst_pkg::LEN_W-1:0] EVENT_LEN,
   output logic [burst_pkg::COL_W-1:0] EVENT_COL
);
   localparam int LW = burst_pkg::LEN_W;
   localparam int CW = burst_pkg::COL_W;
   localparam int HALF = BL / 2;
   localparam int RD_TAP = RL - 3;
   localparam int WR_TAP = WL - 1;
   localparam int DEPTH = RL + WL;
   localparam int RD_LAT = RL;
   localparam int WR_LAT = WL + 2;
   localparam int WR_PRE = WL + 1;
   localparam logic [LW-1:0] HALF_C = LW'(HALF);

   // elaboration check on parameters the logic cannot serve
   if (!(BL == 4 || BL == 8 || BL == 16) || RL < 3 || WL < 1 ||
       MEM_AW < 4 || MEM_AW > CW) begin : g_bad_param
      $error("burst_engine: unsupported parameter set");
   end

   // column of one beat, wrapping inside the burst
   function automatic logic [MEM_AW-1:0] burst_addr(
      input logic [CW-1:0] start,
      input logic [LW-1:0] beat);
      logic [CW-1:0] mask;
      logic [CW-1:0] sum;
      mask = CW'(BL - 1);
      sum = start + CW'(beat);
      burst_addr = MEM_AW'((start & ~mask) | (sum & mask));
   endfunction : burst_addr

   // reset release, one synchroniser per domain
   logic [1:0] core_rst_reg;
   logic [1:0] link_rst_reg;
   logic core_rst_n;
   logic link_rst_n;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         core_rst_reg <= burst_pkg::SYNC_RST;
      end else begin
         core_rst_reg <= {core_rst_reg[0], 1'b1};
      end
   end
   always_ff @(posedge LINK_CK or negedge RSTN) begin
      if (!RSTN) begin
         link_rst_reg <= burst_pkg::SYNC_RST;
      end else begin
         link_rst_reg <= {link_rst_reg[0], 1'b1};
      end
   end
   assign core_rst_n = core_rst_reg[1];
   assign link_rst_n = link_rst_reg[1];

   // falling-edge half of the command bus
   logic [burst_pkg::CA_W-1:0] fall_reg;
   always_ff @(negedge LINK_CK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         fall_reg <= '0;
      end else begin
         fall_reg <= CMD_ADDR_BUS;
      end
   end

   // command decode on the rising edge
   logic cmd_sel, cmd_rd, cmd_wr, cmd_bst, cmd_any;
   assign cmd_sel = !SELECT_N && CMD_ADDR_BUS[burst_pkg::BIT_ACC];
   assign cmd_rd = cmd_sel && !CMD_ADDR_BUS[burst_pkg::BIT_KIND] &&
                   CMD_ADDR_BUS[burst_pkg::BIT_RD];
   assign cmd_wr = cmd_sel && !CMD_ADDR_BUS[burst_pkg::BIT_KIND] &&
                   !CMD_ADDR_BUS[burst_pkg::BIT_RD];
   assign cmd_bst = cmd_sel && CMD_ADDR_BUS[burst_pkg::BIT_KIND] &&
                    !CMD_ADDR_BUS[burst_pkg::BIT_RD] &&
                    !CMD_ADDR_BUS[burst_pkg::BIT_SUB];
   assign cmd_any = cmd_rd || cmd_wr;

   // burst tracking state
   logic pend_valid_reg, pend_valid_next;
   logic pend_read_reg, pend_read_next;
   logic [1:0] pend_hi_reg, pend_hi_next;
   logic stop_pend_reg, stop_pend_next;
   logic last_read_reg, last_read_next;
   logic open_reg, open_next;
   logic [LW-1:0] since_reg, since_next;
   logic [CW-1:0] cur_col_reg, cur_col_next;
   logic hold_read_reg, hold_read_next;
   logic [LW-1:0] hold_len_reg, hold_len_next;
   logic [CW-1:0] hold_col_reg, hold_col_next;
   logic hold_tgl_reg, hold_tgl_next;
   logic [CW-1:0] col_now;
   logic stop_ok, rep_fire;

   // column completes one half cycle after the command
   assign col_now = {pend_hi_reg, fall_reg[burst_pkg::COL_FALL_HI:
                                           burst_pkg::COL_FALL_LO]};
   // stop only inside the newest burst, on an even clock
   assign stop_ok = cmd_bst && open_reg && since_reg != '0 &&
                    !since_reg[0] && since_reg < HALF_C;
   // length closes at end, interrupt or stop
   assign rep_fire = open_reg && (since_reg == HALF_C || cmd_any ||
                                  stop_ok);

   always_comb begin
      pend_valid_next = cmd_any;
      pend_read_next = cmd_rd;
      pend_hi_next = CMD_ADDR_BUS[burst_pkg::COL_RISE_HI:
                                  burst_pkg::COL_RISE_LO];
      stop_pend_next = stop_ok;
      last_read_next = cmd_any ? cmd_rd : last_read_reg;
      cur_col_next = pend_valid_reg ? col_now : cur_col_reg;
      open_next = open_reg;
      since_next = since_reg;
      hold_read_next = hold_read_reg;
      hold_len_next = hold_len_reg;
      hold_col_next = hold_col_reg;
      hold_tgl_next = hold_tgl_reg;
      if (since_reg < HALF_C) begin
         since_next = since_reg + 5'h1;
      end
      // twice the clocks since the command
      if (rep_fire) begin
         open_next = 1'b0;
         hold_read_next = last_read_reg;
         hold_len_next = {since_reg[LW-2:0], 1'b0};
         hold_col_next = pend_valid_reg ? col_now : cur_col_reg;
         hold_tgl_next = !hold_tgl_reg;
      end
      if (cmd_any) begin
         open_next = 1'b1;
         since_next = 5'h1;
      end
   end

   always_ff @(posedge LINK_CK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         pend_valid_reg <= 1'b0;
         pend_read_reg <= 1'b0;
         pend_hi_reg <= 2'h0;
         stop_pend_reg <= 1'b0;
         last_read_reg <= 1'b0;
         open_reg <= 1'b0;
         since_reg <= burst_pkg::SINCE_RST;
         cur_col_reg <= '0;
         hold_read_reg <= 1'b0;
         hold_len_reg <= '0;
         hold_col_reg <= '0;
         hold_tgl_reg <= 1'b0;
      end else begin
         pend_valid_reg <= pend_valid_next;
         pend_read_reg <= pend_read_next;
         pend_hi_reg <= pend_hi_next;
         stop_pend_reg <= stop_pend_next;
         last_read_reg <= last_read_next;
         open_reg <= open_next;
         since_reg <= since_next;
         cur_col_reg <= cur_col_next;
         hold_read_reg <= hold_read_next;
         hold_len_reg <= hold_len_next;
         hold_col_reg <= hold_col_next;
         hold_tgl_reg <= hold_tgl_next;
      end
   end

   // latency line: starts and stops travel the same path, so a stop
   // cuts the data exactly where the matching latency puts it
   logic sh_valid_reg [DEPTH], sh_valid_next [DEPTH];
   logic sh_stop_reg [DEPTH], sh_stop_next [DEPTH];
   logic sh_read_reg [DEPTH], sh_read_next [DEPTH];
   logic [CW-1:0] sh_col_reg [DEPTH], sh_col_next [DEPTH];

   always_comb begin
      sh_valid_next[0] = pend_valid_reg || stop_pend_reg;
      sh_stop_next[0] = stop_pend_reg;
      // stop follows the kind of the newest command
      sh_read_next[0] = pend_valid_reg ? pend_read_reg : last_read_reg;
      sh_col_next[0] = col_now;
      for (int i = 1; i < DEPTH; i++) begin
         sh_valid_next[i] = sh_valid_reg[i-1];
         sh_stop_next[i] = sh_stop_reg[i-1];
         sh_read_next[i] = sh_read_reg[i-1];
         sh_col_next[i] = sh_col_reg[i-1];
      end
   end

   always_ff @(posedge LINK_CK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            sh_valid_reg[i] <= 1'b0;
            sh_stop_reg[i] <= 1'b0;
            sh_read_reg[i] <= 1'b0;
            sh_col_reg[i] <= '0;
         end
      end else begin
         sh_valid_reg <= sh_valid_next;
         sh_stop_reg <= sh_stop_next;
         sh_read_reg <= sh_read_next;
         sh_col_reg <= sh_col_next;
      end
   end

   // data engine: one rise/fall pair per link cycle
   burst_pkg::eng_state_type state_reg, state_next;
   logic eng_read_reg, eng_read_next;
   logic [CW-1:0] start_reg, start_next;
   logic [LW-1:0] beat_reg, beat_next;
   logic [LW-1:0] left_reg, left_next;
   logic rd_hit, wr_hit, hit, tap_stop, tap_read, load_rd;
   logic [CW-1:0] tap_col;
   logic take, rd_take, wr_take;
   logic [MEM_AW-1:0] addr0, addr1;

   assign rd_hit = sh_valid_reg[RD_TAP] && sh_read_reg[RD_TAP];
   assign wr_hit = sh_valid_reg[WR_TAP] && !sh_read_reg[WR_TAP];
   assign hit = rd_hit || wr_hit;
   // turnaround spacing keeps the two taps apart; read wins
   assign tap_stop = rd_hit ? sh_stop_reg[RD_TAP] : sh_stop_reg[WR_TAP];
   assign tap_read = rd_hit;
   assign tap_col = rd_hit ? sh_col_reg[RD_TAP] : sh_col_reg[WR_TAP];
   assign load_rd = rd_hit && !tap_stop;
   assign take = state_reg == burst_pkg::ENG_XFER;
   assign rd_take = take && eng_read_reg;
   // first pair sampled WL+2 cycles after the write command
   assign wr_take = take && !eng_read_reg;
   assign addr0 = burst_addr(start_reg, beat_reg);
   assign addr1 = burst_addr(start_reg, beat_reg + 5'h1);

   always_comb begin
      state_next = state_reg;
      eng_read_next = eng_read_reg;
      start_next = start_reg;
      beat_next = beat_reg;
      left_next = left_reg;
      // one pair per cycle until the burst is done
      if (take) begin
         beat_next = beat_reg + 5'h2;
         left_next = left_reg - 5'h1;
         if (left_reg == 5'h1) begin
            state_next = burst_pkg::ENG_IDLE;
         end
      end
      // stop ends the burst after the latency
      if (hit && tap_stop) begin
         state_next = burst_pkg::ENG_IDLE;
      // a new burst takes over seamlessly
      end else if (hit) begin
         state_next = burst_pkg::ENG_XFER;
         eng_read_next = tap_read;
         start_next = tap_col;
         beat_next = '0;
         left_next = HALF_C;
      end
   end

   always_ff @(posedge LINK_CK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         state_reg <= burst_pkg::ENG_IDLE;
         eng_read_reg <= 1'b0;
         start_reg <= '0;
         beat_reg <= '0;
         left_reg <= '0;
      end else begin
         state_reg <= state_next;
         eng_read_reg <= eng_read_next;
         start_reg <= start_next;
         beat_reg <= beat_next;
         left_reg <= left_next;
      end
   end

   // storage behind the pins; no reset, data only
   logic [DATA_W-1:0] mem [2**MEM_AW];
   always_ff @(posedge LINK_CK) begin
      if (wr_take) begin
         mem[addr0] <= WDATA_RISE;
         mem[addr1] <= WDATA_FALL;
      end
   end

   // read pins, registered so the pad sees clean edges
   logic [DATA_W-1:0] rd_rise_reg, rd_rise_next;
   logic [DATA_W-1:0] rd_fall_reg, rd_fall_next;
   logic rd_oe_reg, rd_oe_next, dqs_oe_reg, dqs_oe_next;
   logic dqs_run_reg, dqs_run_next;
   always_comb begin
      rd_rise_next = rd_take ? mem[addr0] : rd_rise_reg;
      rd_fall_next = rd_take ? mem[addr1] : rd_fall_reg;
      rd_oe_next = rd_take;
      // strobe held low one cycle ahead of the data
      dqs_oe_next = rd_take || load_rd;
      dqs_run_next = rd_take;
   end
   always_ff @(posedge LINK_CK or negedge link_rst_n) begin
      if (!link_rst_n) begin
         rd_rise_reg <= '0;
         rd_fall_reg <= '0;
         rd_oe_reg <= 1'b0;
         dqs_oe_reg <= 1'b0;
         dqs_run_reg <= 1'b0;
      end else begin
         rd_rise_reg <= rd_rise_next;
         rd_fall_reg <= rd_fall_next;
         rd_oe_reg <= rd_oe_next;
         dqs_oe_reg <= dqs_oe_next;
         dqs_run_reg <= dqs_run_next;
      end
   end
   assign RDATA_RISE = rd_rise_reg;
   assign RDATA_FALL = rd_fall_reg;
   assign DQ_OE_N = !rd_oe_reg;
   assign DQS_OE_N = !dqs_oe_reg;
   assign DQS_RUN = dqs_run_reg;

   // burst reports cross by toggle; the held word is stable for at
   // least two link cycles, far longer than the three-flop sync
   logic [2:0] ev_sync_reg;
   logic ev_valid_reg, ev_valid_next, ev_read_reg, ev_read_next;
   logic [LW-1:0] ev_len_reg, ev_len_next;
   logic [CW-1:0] ev_col_reg, ev_col_next;
   logic ev_edge;
   assign ev_edge = ev_sync_reg[2] ^ ev_sync_reg[1];
   always_comb begin
      ev_valid_next = ev_edge;
      ev_read_next = ev_edge ? hold_read_reg : ev_read_reg;
      ev_len_next = ev_edge ? hold_len_reg : ev_len_reg;
      ev_col_next = ev_edge ? hold_col_reg : ev_col_reg;
   end
   always_ff @(posedge CLOCK or negedge core_rst_n) begin
      if (!core_rst_n) begin
         ev_sync_reg <= 3'h0;
         ev_valid_reg <= 1'b0;
         ev_read_reg <= 1'b0;
         ev_len_reg <= '0;
         ev_col_reg <= '0;
      end else begin
         ev_sync_reg <= {ev_sync_reg[1:0], hold_tgl_reg};
         ev_valid_reg <= ev_valid_next;
         ev_read_reg <= ev_read_next;
         ev_len_reg <= ev_len_next;
         ev_col_reg <= ev_col_next;
      end
   end
   assign EVENT_VALID = ev_valid_reg;
   assign EVENT_READ = ev_read_reg;
   assign EVENT_LEN = ev_len_reg;
   assign EVENT_COL = ev_col_reg;

   // checks on the link side; the report cover runs on CLOCK
   chk_write_decode: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) cmd_wr |=> pend_valid_reg && !pend_read_reg)
      else $error("write not decoded");
   chk_read_decode: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) cmd_rd |=> pend_valid_reg && pend_read_reg)
      else $error("read not decoded");
   chk_col_capture: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) pend_valid_reg |=> sh_col_reg[0] ==
      $past(col_now)) else $error("column not captured");
   chk_read_latency: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) cmd_rd |-> ##RD_LAT dqs_oe_reg ##1
      (rd_oe_reg && dqs_run_reg)) else $error("read latency wrong");
   chk_write_sample: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) cmd_wr |-> ##WR_LAT wr_take)
      else $error("write pair not sampled");
   chk_seamless_read: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) (cmd_rd ##HALF cmd_rd) |->
      ##RD_LAT rd_oe_reg[*2]) else $error("gap in seamless read");
   chk_seamless_write: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) (cmd_wr ##HALF cmd_wr) |->
      ##WR_PRE wr_take[*2]) else $error("gap in seamless write");
   chk_write_interrupt: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) (cmd_wr ##1 !cmd_any ##1 cmd_wr) |=>
      hold_len_reg == 5'h4 && !hold_read_reg)
      else $error("interrupted write length wrong");
   chk_stop_length: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) (BL > 4 && cmd_rd ##1 !cmd_any ##1
      cmd_bst) |=> hold_len_reg == 5'h4 && hold_read_reg)
      else $error("stopped read length wrong");
   chk_stop_decode: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) (BL > 4 && cmd_any ##1 !cmd_any ##1
      cmd_bst) |-> ##2 (sh_valid_reg[0] && sh_stop_reg[0]))
      else $error("burst stop not decoded");
   chk_stop_recent: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) (cmd_bst && !open_reg) |=> !stop_pend_reg)
      else $error("stop acted on a closed burst");
   chk_stop_end_rd: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) (stop_ok && last_read_reg) |->
      ##RD_LAT state_reg == burst_pkg::ENG_IDLE)
      else $error("stopped read kept running");
   chk_stop_end_wr: assert property (@(posedge LINK_CK)
      disable iff (!link_rst_n) (stop_ok && !last_read_reg) |->
      ##WR_LAT state_reg == burst_pkg::ENG_IDLE)
      else $error("stopped write kept running");
   cov_seamless_read: cover property (@(posedge LINK_CK)
      disable iff (!link_rst_n) cmd_rd ##HALF cmd_rd);
   cov_write_interrupt: cover property (@(posedge LINK_CK)
      disable iff (!link_rst_n) cmd_wr ##2 cmd_wr);
   cov_read_stop: cover property (@(posedge LINK_CK)
      disable iff (!link_rst_n) stop_ok && last_read_reg);
   cov_event_out: cover property (@(posedge CLOCK)
      disable iff (!core_rst_n) ev_valid_reg);
endmodule : burst_engine

// [design/burst_pkg.sv]
/*
 * shared constants for the burst sequencer: command decode bit positions,
 * column field layout, widths, default latencies and engine states.
 * assumes nothing of its surroundings.
 */
package burst_pkg;
   // command and address bus
   localparam int CA_W = 10;
   localparam int BIT_ACC = 0;
   localparam int BIT_KIND = 1;
   localparam int BIT_RD = 2;
   localparam int BIT_SUB = 3;
   // column field: rise bits 6..5, fall bits 9..1
   localparam int COL_RISE_HI = 6;
   localparam int COL_RISE_LO = 5;
   localparam int COL_FALL_HI = 9;
   localparam int COL_FALL_LO = 1;
   localparam int COL_W = 11;
   // burst length counters
   localparam int LEN_W = 5;
   // defaults
   localparam int BL_DEF = 8;
   localparam int RL_DEF = 3;
   localparam int WL_DEF = 1;
   localparam int DATA_W_DEF = 16;
   localparam int MEM_AW_DEF = 6;
   // reset values
   localparam logic [LEN_W-1:0] SINCE_RST = 5'h0;
   localparam logic [1:0] SYNC_RST = 2'h0;

   typedef enum logic {
      ENG_IDLE = 1'b0,
      ENG_XFER = 1'b1
   } eng_state_type;
endpackage : burst_pkg

// [tb/burst_engine_tb.sv]
/*
 * self-checking bench of the burst engine: random seamless bursts, then
 * interrupted and stopped bursts. assumes ctrl_model drives the link.
 */
`timescale 1ns/1ps
module burst_engine_tb;
   localparam int BL = 8;
   localparam int RL = 3;
   logic clock = 1'b0;
   logic link_ck = 1'b0;
   logic rstn = 1'b0;
   logic select_n, dq_oe_n, dqs_oe_n, dqs_run, ev_valid, ev_read;
   logic [burst_pkg::CA_W-1:0] ca;
   logic [15:0] wr_r, wr_f, rd_r, rd_f, d, d2;
   logic [4:0] ev_len;
   logic [10:0] ev_col, c, c2;
   logic [31:0] rq[$];
   logic [31:0] evq[$];
   int runs[$];
   logic [15:0] mem[int];
   int run = 0, n_mismatch = 0, cmp_count = 0, l2;
   logic pdqs_n = 1'b1;
   logic [31:0] seed = 32'h49dc5fee;
   initial forever #2.5 clock = ~clock;
   initial #37 forever #80 link_ck = ~link_ck;
   burst_engine #(.BL(BL), .RL(RL)) dut_u (
      .CLOCK(clock), .RSTN(rstn), .LINK_CK(link_ck), .SELECT_N(select_n),
      .CMD_ADDR_BUS(ca), .WDATA_RISE(wr_r), .WDATA_FALL(wr_f),
      .RDATA_RISE(rd_r), .RDATA_FALL(rd_f), .DQ_OE_N(dq_oe_n),
      .DQS_OE_N(dqs_oe_n), .DQS_RUN(dqs_run), .EVENT_VALID(ev_valid),
      .EVENT_READ(ev_read), .EVENT_LEN(ev_len), .EVENT_COL(ev_col));
   ctrl_model #(.BL(BL), .WL(1)) ctl_u (.link_ck(link_ck),
      .select_n(select_n), .cmd_addr_bus(ca), .wdata_rise(wr_r),
      .wdata_fall(wr_f));
   // read pairs, run lengths of read data, strobe ahead of data
   always @(posedge link_ck) begin
      pdqs_n <= dqs_oe_n;
      if (dq_oe_n === 1'b0) begin
         rq.push_back({rd_r, rd_f});
         run++;
         check("strobe", {pdqs_n, dqs_run}, 2'h1);
      end else if (run > 0) begin
         runs.push_back(run);
         run = 0;
      end
   end
   // burst reports
   always @(posedge clock) begin
      if (ev_valid === 1'b1) evq.push_back({ev_read, ev_len, ev_col});
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // column wraps inside its burst-aligned block
   function automatic int addr(input int s, input int b);
      return ((s & ~(BL - 1)) | ((s + b) & (BL - 1))) &
         ((1 << burst_pkg::MEM_AW_DEF) - 1);
   endfunction : addr
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic gap(input int n);
      repeat (n) @(posedge link_ck);
   endtask : gap
   task automatic wr(input int s, input logic [15:0] v, input int len);
      for (int b = 0; b < len; b++) mem[addr(s, b)] = v + 16'(b);
   endtask : wr
   task automatic rd_chk(input int s, input int len);
      for (int k = 0; k < len / 2; k++) check("rdata",
         rq.size() ? rq.pop_front() : 32'hx,
         {mem[addr(s, 2 * k)], mem[addr(s, 2 * k + 1)]});
   endtask : rd_chk
   task automatic ev_chk(input logic rd, input int len, input int s);
      check("event", evq.size() ? evq.pop_front() : 32'hx,
         {rd, 5'(len), 11'(s)});
   endtask : ev_chk
   // bounded wait for reports, then the read latency drains the data
   task automatic wait_ev(input int n);
      int t;
      for (t = 0; t < 4000 && evq.size() < n; t++) @(posedge clock);
      if (t == 4000) begin
         n_mismatch++;
         stop_test();
      end else gap(RL + 3);
   endtask : wait_ev
   initial begin
      repeat (20) @(posedge clock);
      gap(3);
      @(posedge clock);
      rstn <= 1'b1;
      check("idle", {dq_oe_n, dqs_oe_n, dqs_run, ev_valid}, 4'hc);
      gap(4);
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         c = seed[10:0];
         c2 = c ^ 11'h8;
         d = seed[31:16];
         d2 = ~d;
         l2 = (i < 6) ? BL : (i == 6 ? BL : 4);
         // bursts BL/2 clocks apart, then cut or stopped ones
         // cuts on even clocks by the same kind only
         for (int k = 1; k >= 0; k--) begin
            if (k == 1) wr(c, d, i < 6 ? BL : 4);
            if (k == 1) wr(c2, d2, l2);
            ctl_u.cmd(k, c, d);
            if (i < 6) gap(2);
            ctl_u.cmd(k, c2, d2);
            if (i == 7) ctl_u.cmd(2, c, d);
            wait_ev(2);
            ev_chk(!k, i < 6 ? BL : 4, c);
            ev_chk(!k, l2, c2);
         end
         check("run", runs.size() ? runs.pop_front() : 32'hx,
            (i < 6 ? BL / 2 : 2) + l2 / 2);
         rd_chk(c, i < 6 ? BL : 4);
         rd_chk(c2, l2);
      end
      // a code with bit 3 high two clocks into a read must not cut it
      wr(c, d, BL);
      ctl_u.cmd(1, c, d);
      wait_ev(1);
      ev_chk(1'b0, BL, c);
      ctl_u.cmd(0, c, d);
      ctl_u.cmd(3, c, d);
      wait_ev(1);
      ev_chk(1'b1, BL, c);
      check("run", runs.size() ? runs.pop_front() : 32'hx, BL / 2);
      rd_chk(c, BL);
      check("ignored", evq.size(), 32'h0);
      stop_test();
   end
endmodule : burst_engine_tb

// [tb/ctrl_model.sv]
/*
 * controller model for the link side: commands, column fields, write pairs.
 * assumes the bench supplies link_ck and calls cmd from one process.
 */
`timescale 1ns/1ps
module ctrl_model #(
   parameter int BL = 8,
   parameter int WL = 1
) (
   input wire logic link_ck,
   output logic select_n,
   output logic [burst_pkg::CA_W-1:0] cmd_addr_bus,
   output logic [15:0] wdata_rise,
   output logic [15:0] wdata_fall
);
   int gen = 0;
   int cnt = 0;
   int last_t = 0;
   int keep = 0;
   int cut = 0;
   initial begin
      select_n = 1'b1;
      cmd_addr_bus = 10'h0;
      wdata_rise = 16'h0;
      wdata_fall = 16'hffff;
   end
   // cycle count moves on the falling edge, away from command edges
   always @(negedge link_ck) cnt <= cnt + 1;
   // kind 0 read, 1 write, 2 stop, 3 a code the device ignores
   task automatic cmd(input int kind, input logic [10:0] col,
      input logic [15:0] d);
      int my;
      logic [3:0] op;
      op = kind == 0 ? 4'h5 : kind == 1 ? 4'h1 : kind == 2 ? 4'h3 : 4'hb;
      @(posedge link_ck);
      select_n <= 1'b0;
      // rise half stands at the command edge, fall half after it
      cmd_addr_bus <= {3'h0, col[10:9], 1'h0, op};
      @(posedge link_ck);
      select_n <= 1'b1;
      cmd_addr_bus <= {col[8:0], 1'h0};
      // stop trims only the latest write
      if (kind == 2) keep = cnt - last_t;
      if (kind == 1) begin
         gen++;
         // clocks since the previous write: its share of the lines
         cut = cnt - last_t;
         keep = BL / 2;
         last_t = cnt;
      end
      my = gen;
      // pair k ready for sampling at edge t0+WL+2+k
      if (kind == 1) fork
         begin
            repeat (WL + 1) @(posedge link_ck);
            for (int k = 0; k <= BL / 2; k++) begin
               @(negedge link_ck);
               // a newer write owns the lines from its first pair on
               if (my != gen && k >= cut) break;
               if (k < keep) begin
                  wdata_rise <= d + 16'(2 * k);
                  wdata_fall <= d + 16'(2 * k + 1);
               end else begin
                  // released lines must not keep the last beat
                  wdata_rise <= ~wdata_rise;
                  wdata_fall <= ~wdata_fall;
                  break;
               end
            end
         end
      join_none
   endtask : cmd
endmodule : ctrl_model
